// File: rtl/habs_pkg.sv
/*
 * Shared constants of the host access bridge: register slots of the processor
 * side, field positions (big-endian numbering mapped onto logic bit 31-n),
 * address codes and reset values. Assumes nothing of its surroundings.
 */
package habs_pkg;

    // ************************************************************
    // Direct register slots on the processor bus
    // ************************************************************
    localparam logic [1:0]  HABS_SLOT_HIGH_DATA = 2'h0;
    localparam logic [1:0]  HABS_SLOT_LOW_DATA  = 2'h1;
    localparam logic [1:0]  HABS_SLOT_COMMAND   = 2'h2;
    localparam logic [1:0]  HABS_SLOT_READY     = 2'h3;

    // ************************************************************
    // Field positions, little-endian bit index = 31 - printed bit
    // ************************************************************
    localparam int          HABS_CMD_WE_BIT     = 15;
    localparam int          HABS_CMD_CODE_LSB   = 0;
    localparam int          HABS_CMD_CODE_W     = 10;
    localparam int          HABS_RDY_ALL_BIT    = 16;
    localparam int          HABS_TYPE_LSB       = 0;
    localparam int          HABS_NUM_TYPES      = 7;
    localparam int          HABS_MGMT_DATA_W    = 16;

    // Type index inside the seven-bit group, LSB first
    localparam int          HABS_T_USER_RD      = 0;
    localparam int          HABS_T_MGMT_RD      = 1;
    localparam int          HABS_T_MGMT_WR      = 2;
    localparam int          HABS_T_FILT_RD      = 3;
    localparam int          HABS_T_FILT_WR      = 4;
    localparam int          HABS_T_CFG_RD       = 5;
    localparam int          HABS_T_CFG_WR       = 6;

    // ************************************************************
    // Address codes
    // ************************************************************
    localparam logic [9:0]  HABS_AC_USER_LO_END = 10'h02f;
    localparam logic [9:0]  HABS_AC_USER_HI_BEG = 10'h040;
    localparam logic [9:0]  HABS_AC_USER_HI_END = 10'h04f;
    localparam logic [9:0]  HABS_AC_MAC_BEG     = 10'h200;
    localparam logic [9:0]  HABS_AC_FILT_BEG    = 10'h380;
    localparam logic [9:0]  HABS_AC_MAC_END     = 10'h390;
    localparam logic [9:0]  HABS_AC_IRQ_STATUS  = 10'h3a0;
    localparam logic [9:0]  HABS_AC_IRQ_ENABLE  = 10'h3a4;
    localparam logic [9:0]  HABS_AC_MGMT_WDATA  = 10'h3b0;
    localparam logic [9:0]  HABS_AC_MGMT_ACCESS = 10'h3b4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] HABS_CMD_RST        = 32'h0000_0000;
    localparam logic [6:0]  HABS_READY_RST      = 7'h7f;
    localparam logic [6:0]  HABS_IRQ_RST        = 7'h00;
    localparam logic [15:0] HABS_MGMT_WDATA_RST = 16'h0000;

endpackage

// File: rtl/habs_cmd_decode.sv
/*
 * Address code decoder: turns a command word into the access type strobe
 * vector and local-register selects. Pure combinational, same clock domain.
 */
`timescale 1ns/1ps
module habs_cmd_decode
    import habs_pkg::*;
(
    input  wire logic [31:0] cmd,
    output logic [6:0]       type_onehot,
    output logic             sel_irq_status,
    output logic             sel_irq_enable,
    output logic             sel_mgmt_wdata,
    output logic             is_write
);
    logic [9:0] code;

    always_comb begin
        code           = cmd[HABS_CMD_CODE_LSB +: HABS_CMD_CODE_W];
        is_write       = cmd[HABS_CMD_WE_BIT];
        type_onehot    = 7'h00;
        sel_irq_status = (code == HABS_AC_IRQ_STATUS);
        sel_irq_enable = (code == HABS_AC_IRQ_ENABLE);
        sel_mgmt_wdata = (code == HABS_AC_MGMT_WDATA);
        if (code <= HABS_AC_USER_LO_END ||
            (code >= HABS_AC_USER_HI_BEG && code <= HABS_AC_USER_HI_END)) begin
            // User logic is read only; a write request there does nothing
            type_onehot[HABS_T_USER_RD] = !is_write;
        end else if (code >= HABS_AC_FILT_BEG && code <= HABS_AC_MAC_END) begin
            type_onehot[is_write ? HABS_T_FILT_WR : HABS_T_FILT_RD] = 1'b1;
        end else if (code >= HABS_AC_MAC_BEG && code < HABS_AC_FILT_BEG) begin
            type_onehot[is_write ? HABS_T_CFG_WR : HABS_T_CFG_RD] = 1'b1;
        end else if (code == HABS_AC_MGMT_ACCESS) begin
            type_onehot[is_write ? HABS_T_MGMT_WR : HABS_T_MGMT_RD] = 1'b1;
        end
    end
endmodule

// File: rtl/habs_pin_sync.sv
/*
 * Two flip-flop synchroniser for a group of level inputs from pins.
 * Assumes each bit is a level that stays long enough to be seen.
 */
`timescale 1ns/1ps
module habs_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0]      sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } habs_sync_t;

    habs_sync_t st_r;
    habs_sync_t st_nxt;

    // A zero-width group would leave nothing to synchronise
    if (WIDTH < 1) begin : g_width_check
        $error("habs_pin_sync needs WIDTH of at least 1");
    end

    always_comb begin
        st_nxt.meta   = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;
endmodule

// File: rtl/habs_bridge.sv
/*
 * Processor-side host access bridge: command register, per-type ready flags,
 * completion interrupt status/enable, management write data and the request
 * handshake toward the MAC host interface. Assumes the processor bus is a
 * simple same-clock select/write/read port and the MAC side answers each
 * request with a one-cycle done pulse on mclk.
 */
`timescale 1ns/1ps

module habs_bridge
    import habs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    // Processor register port
    input  wire logic        bus_sel,
    input  wire logic        bus_write,
    input  wire logic [1:0]  bus_slot,
    input  wire logic [31:0] bus_wdata,
    output logic [31:0]      bus_rdata,
    // MAC host interface
    output logic             host_req,
    output logic             host_write,
    output logic [9:0]       host_addr_code,
    output logic [31:0]      host_wdata,
    input  wire logic        host_done,
    input  wire logic [31:0] host_rdata_low,
    input  wire logic [31:0] host_rdata_high,
    // Bus-based access in use (pin strap)
    input  wire logic        bus_access_mode,
    // Completion interrupt
    output logic             host_access_done_irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {
        HABS_IDLE,
        HABS_WAIT
    } habs_state_t;

    typedef struct packed {
        habs_state_t state;
        logic [31:0] command;
        logic [31:0] low_data_word;
        logic [31:0] high_data_word;
        logic [6:0]  ready;
        logic [6:0]  irq_status;
        logic [6:0]  irq_enable;
        logic [15:0] mgmt_wdata;
        logic [6:0]  active_type;
        logic        req;
        logic [31:0] rdata;
    } habs_regs_t;

    habs_regs_t st_r;
    habs_regs_t st_nxt;

    logic [6:0]  dec_type;
    logic        dec_irq_status;
    logic        dec_irq_enable;
    logic        dec_mgmt_wdata;
    logic        dec_write;
    logic        mode_sync;
    logic [31:0] cmd_word;

    function automatic logic [31:0] habs_place7(input logic [6:0] v);
        // Seven type bits land on printed bits 25..31
        habs_place7 = {25'h0000000, v};
    endfunction

    assign cmd_word = bus_wdata & 32'h0000_83ff;

    habs_cmd_decode u_dec (
        .cmd            (cmd_word),
        .type_onehot    (dec_type),
        .sel_irq_status (dec_irq_status),
        .sel_irq_enable (dec_irq_enable),
        .sel_mgmt_wdata (dec_mgmt_wdata),
        .is_write       (dec_write)
    );

    // Strap comes from a pin, so it is synchronised before use
    habs_pin_sync #(.WIDTH(1)) u_mode_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in (bus_access_mode),
        .sync_out (mode_sync)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic cmd_wr;
        logic busy;
        cmd_wr = 1'b0;
        busy   = 1'b0;
        st_nxt = st_r;
        st_nxt.req = 1'b0;
        cmd_wr = bus_sel && bus_write && (bus_slot == HABS_SLOT_COMMAND);
        busy   = (st_r.state != HABS_IDLE);

        // Data registers; a read result overwrites them
        if (bus_sel && bus_write && bus_slot == HABS_SLOT_LOW_DATA) begin
            st_nxt.low_data_word = bus_wdata;
        end
        if (bus_sel && bus_write && bus_slot == HABS_SLOT_HIGH_DATA) begin
            st_nxt.high_data_word = bus_wdata;
        end

        // Completion: ready flag back up, enabled status set
        if (busy && host_done) begin
            st_nxt.state = HABS_IDLE;
            st_nxt.ready = st_r.ready | st_r.active_type;
            st_nxt.irq_status = st_r.irq_status | (st_r.active_type & st_r.irq_enable);
            if (!st_r.command[HABS_CMD_WE_BIT]) begin
                st_nxt.low_data_word  = host_rdata_low;
                st_nxt.high_data_word = host_rdata_high;
            end
        end

        // New command only while idle; otherwise dropped silently
        if (cmd_wr && !busy) begin
            st_nxt.command = cmd_word;
            if (dec_irq_status) begin
                if (dec_write) begin
                    st_nxt.irq_status = st_r.low_data_word[6:0];
                end else begin
                    st_nxt.low_data_word = habs_place7(st_r.irq_status);
                end
            end else if (dec_irq_enable) begin
                if (dec_write) begin
                    st_nxt.irq_enable = st_r.low_data_word[6:0];
                end else begin
                    st_nxt.low_data_word = habs_place7(st_r.irq_enable);
                end
            end else if (dec_mgmt_wdata) begin
                if (dec_write) begin
                    st_nxt.mgmt_wdata = st_r.low_data_word[HABS_MGMT_DATA_W-1:0];
                end else begin
                    st_nxt.low_data_word = {16'h0000, st_r.mgmt_wdata};
                end
            end else if (dec_type != 7'h00) begin
                st_nxt.state       = HABS_WAIT;
                st_nxt.active_type = dec_type;
                st_nxt.ready       = st_r.ready & ~dec_type;
                st_nxt.req         = 1'b1;
            end
        end

        // Ready register is never written by the bus
        // Read data follows the slot on every edge; a read sees it one cycle on
        case (bus_slot)
            HABS_SLOT_HIGH_DATA: st_nxt.rdata = st_r.high_data_word;
            HABS_SLOT_LOW_DATA:  st_nxt.rdata = st_r.low_data_word;
            HABS_SLOT_COMMAND:   st_nxt.rdata = st_r.command;
            HABS_SLOT_READY: begin
                st_nxt.rdata = habs_place7(st_r.ready);
                st_nxt.rdata[HABS_RDY_ALL_BIT] = &st_r.ready;
            end
            default:             st_nxt.rdata = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r.state          <= HABS_IDLE;
            st_r.command        <= HABS_CMD_RST;
            st_r.low_data_word  <= 32'h0000_0000;
            st_r.high_data_word <= 32'h0000_0000;
            st_r.ready          <= HABS_READY_RST;
            st_r.irq_status     <= HABS_IRQ_RST;
            st_r.irq_enable     <= HABS_IRQ_RST;
            st_r.mgmt_wdata     <= HABS_MGMT_WDATA_RST;
            st_r.active_type    <= 7'h00;
            st_r.req            <= 1'b0;
            st_r.rdata          <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Management write carries the held data, others the low data word
    assign host_req       = st_r.req;
    assign host_write     = st_r.command[HABS_CMD_WE_BIT];
    assign host_addr_code = st_r.command[HABS_CMD_CODE_LSB +: HABS_CMD_CODE_W];
    assign host_wdata     = st_r.active_type[HABS_T_MGMT_WR] ?
                            {16'h0000, st_r.mgmt_wdata} : st_r.low_data_word;
    assign bus_rdata      = st_r.rdata;
    assign host_access_done_irq = mode_sync && (|st_r.irq_status);

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_start;
        st_r.req;
    endsequence

    sequence s_done;
        st_r.state == HABS_WAIT && host_done;
    endsequence

    property p_ready_drops;
        @(posedge mclk) disable iff (reset)
        s_start |-> (st_r.ready & st_r.active_type) == 7'h00;
    endproperty
    a_ready_drops: assert property (p_ready_drops) else $error("ready not cleared");

    property p_ready_rises;
        @(posedge mclk) disable iff (reset)
        (st_r.state == HABS_WAIT && host_done) |=>
            (st_r.ready & $past(st_r.active_type)) == $past(st_r.active_type);
    endproperty
    a_ready_rises: assert property (p_ready_rises) else $error("ready not restored");

    property p_summary;
        @(posedge mclk) disable iff (reset)
        (bus_sel && bus_slot == HABS_SLOT_READY) |=>
            bus_rdata[HABS_RDY_ALL_BIT] == (&$past(st_r.ready));
    endproperty
    a_summary: assert property (p_summary) else $error("summary ready wrong");

    property p_ready_ro;
        @(posedge mclk) disable iff (reset)
        (st_r.state == HABS_IDLE && !(bus_sel && bus_write && bus_slot == HABS_SLOT_COMMAND))
            |=> st_r.ready == $past(st_r.ready);
    endproperty
    a_ready_ro: assert property (p_ready_ro) else $error("ready changed by bus");

    property p_busy_ignore;
        @(posedge mclk) disable iff (reset)
        (st_r.state == HABS_WAIT && !host_done) |=> !st_r.req && $stable(st_r.command);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

    property p_masked_status;
        @(posedge mclk) disable iff (reset)
        (st_r.state == HABS_WAIT && host_done && (st_r.active_type & ~st_r.irq_enable) != 7'h00)
            |=> (st_r.irq_status & $past(st_r.active_type & ~st_r.irq_enable))
                == ($past(st_r.irq_status) & $past(st_r.active_type & ~st_r.irq_enable));
    endproperty
    a_masked_status: assert property (p_masked_status) else $error("masked status set");

    property p_status_set;
        @(posedge mclk) disable iff (reset)
        s_done |=> (st_r.irq_status & $past(st_r.active_type & st_r.irq_enable))
                == $past(st_r.active_type & st_r.irq_enable);
    endproperty
    a_status_set: assert property (p_status_set) else $error("status not set");

    property p_irq_on_done;
        @(posedge mclk) disable iff (reset)
        (st_r.state == HABS_WAIT && host_done && (st_r.active_type & st_r.irq_enable) != 7'h00)
            |=> host_access_done_irq || !mode_sync;
    endproperty
    a_irq_on_done: assert property (p_irq_on_done) else $error("interrupt not raised");

    property p_irq_level;
        @(posedge mclk) disable iff (reset)
        (mode_sync && st_r.irq_status != 7'h00) |-> host_access_done_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not asserted");

    // Only a status clear or a falling mode strap may drop the interrupt
    property p_irq_hold;
        @(posedge mclk) disable iff (reset)
        (host_access_done_irq && !bus_sel) |=> host_access_done_irq || !mode_sync;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped alone");

    // Direction and code must match the command word taken one edge earlier
    property p_req_dir;
        @(posedge mclk) disable iff (reset)
        s_start |-> host_write == $past(bus_wdata[HABS_CMD_WE_BIT]);
    endproperty
    a_req_dir: assert property (p_req_dir) else $error("direction mismatch");

    property p_req_code;
        @(posedge mclk) disable iff (reset)
        s_start |-> host_addr_code == $past(bus_wdata[HABS_CMD_CODE_LSB +: HABS_CMD_CODE_W]);
    endproperty
    a_req_code: assert property (p_req_code) else $error("address code mismatch");

endmodule

// File: test/habs_mac_model.sv
/*
 * Behavioural MAC host side: answers each host_req with one host_done
 * pulse after a set delay and records the request. Assumes mclk only.
 */
`timescale 1ns/1ps
module habs_mac_model (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        host_req,
    input  wire logic        host_write,
    input  wire logic [9:0]  host_addr_code,
    input  wire logic [31:0] host_wdata,
    input  wire logic [7:0]  delay,
    output logic             host_done,
    output logic [31:0]      host_rdata_low,
    output logic [31:0]      host_rdata_high,
    output logic [31:0]      last_wdata,
    output logic             last_write,
    output logic [9:0]       last_code,
    output logic [7:0]       req_count
);
    logic [7:0] cnt;
    logic       busy;
    logic       flip;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt        <= 8'h00;
            busy       <= 1'b0;
            flip       <= 1'b0;
            host_done  <= 1'b0;
            last_wdata <= 32'h0000_0000;
            last_write <= 1'b0;
            last_code  <= 10'h000;
            req_count  <= 8'h00;
        end else begin
            flip      <= ~flip;
            host_done <= 1'b0;
            if (host_req) begin
                cnt        <= delay;
                busy       <= 1'b1;
                last_wdata <= host_wdata;
                last_write <= host_write;
                last_code  <= host_addr_code;
                req_count  <= req_count + 8'h01;
            end else if (busy) begin
                if (cnt <= 8'h01) begin
                    host_done <= 1'b1;
                    busy      <= 1'b0;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end
        end
    end
    // Toggling filler outside host_done exposes sampling at the wrong cycle
    assign host_rdata_low  = host_done ? (32'hc0de_0000 | {22'h000000, last_code}) : {32{flip}};
    assign host_rdata_high = host_done ? (32'h0bad_0000 | {22'h000000, last_code}) : {32{~flip}};
endmodule

// File: test/tb.sv
/*
 * Self-checking bench for habs_bridge: slot port read/write tasks and the
 * MAC host side from habs_mac_model. Assumes a single mclk domain.
 */
`timescale 1ns/1ps
module tb;
    import habs_pkg::*;
    logic        mclk, reset, bus_sel, bus_write, bus_access_mode, irq;
    logic        host_req, host_write, host_done, last_write;
    logic [1:0]  bus_slot;
    logic [9:0]  host_addr_code, last_code;
    logic [7:0]  delay, req_count, nreq;
    logic [31:0] bus_wdata, bus_rdata, host_wdata, host_rdata_low, host_rdata_high;
    logic [31:0] last_wdata, r, exp_st;
    logic [15:0] cmds [7];
    int          bits [7];
    int          failures, check_count, i;

    habs_bridge u_habs_bridge (.mclk(mclk), .reset(reset), .bus_sel(bus_sel),
        .bus_write(bus_write), .bus_slot(bus_slot), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .host_req(host_req), .host_write(host_write),
        .host_addr_code(host_addr_code), .host_wdata(host_wdata), .host_done(host_done),
        .host_rdata_low(host_rdata_low), .host_rdata_high(host_rdata_high),
        .bus_access_mode(bus_access_mode), .host_access_done_irq(irq));
    habs_mac_model u_habs_mac_model (.mclk(mclk), .reset(reset), .host_req(host_req),
        .host_write(host_write), .host_addr_code(host_addr_code), .host_wdata(host_wdata),
        .delay(delay), .host_done(host_done), .host_rdata_low(host_rdata_low),
        .host_rdata_high(host_rdata_high), .last_wdata(last_wdata),
        .last_write(last_write), .last_code(last_code), .req_count(req_count));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ************************************************************
    // Bus tasks and comparisons
    // ************************************************************
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle strobe, driven between edges so the taking edge sees it settled
    task automatic wr(input logic [1:0] s, input logic [31:0] d);
        @(negedge mclk);
        {bus_sel, bus_write, bus_slot, bus_wdata} = {2'h3, s, d};
        @(negedge mclk);
        {bus_sel, bus_write} = 2'h0;
    endtask
    task automatic rd(input logic [1:0] s, output logic [31:0] d);
        @(negedge mclk);
        {bus_sel, bus_write, bus_slot} = {2'h2, s};
        @(negedge mclk);
        bus_sel = 1'b0;
        d = bus_rdata;
    endtask
    task automatic rd_local(input logic [9:0] code, output logic [31:0] d);
        wr(2'h2, {22'h000000, code});
        rd(2'h1, d);
    endtask
    task automatic wr_local(input logic [9:0] code, input logic [31:0] v);
        wr(2'h1, v);
        wr(2'h2, {16'h0000, 6'h20, code});
    endtask
    task automatic wait_idle();
        logic [31:0] d;
        int          n;
        d = 32'h0000_0000;
        for (n = 0; n < 100 && d[HABS_RDY_ALL_BIT] !== 1'b1; n++) begin
            rd(2'h3, d);
        end
        if (d[HABS_RDY_ALL_BIT] !== 1'b1) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic mac_access(input logic [15:0] cmd, input int bitn, input logic [31:0] low);
        logic [31:0] d;
        logic [31:0] ew;
        ew = (cmd == 16'h83b4) ? 32'h0000_1234 : low;
        wr(2'h1, low);
        wr(2'h2, {16'h0000, cmd});
        nreq = nreq + 8'h01;
        rd(2'h3, d);
        check32(d, 32'h0000_007f & ~(32'h0000_0001 << bitn));
        wr(2'h2, 32'h0000_0384);
        rd(2'h2, d);
        check32(d, {16'h0000, cmd});
        wait_idle();
        check32({24'h000000, req_count}, {24'h000000, nreq});
        check1(last_write, cmd[15]);
        check32({22'h000000, last_code}, {22'h000000, cmd[9:0]});
        check32(last_wdata, ew);
        if (!cmd[15]) begin
            rd(2'h1, d);
            check32(d, 32'hc0de_0000 | {22'h000000, cmd[9:0]});
            rd(2'h0, d);
            check32(d, 32'h0bad_0000 | {22'h000000, cmd[9:0]});
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {reset, bus_sel, bus_write, bus_slot, bus_wdata} = {3'h4, 2'h0, 32'h0000_0000};
        {bus_access_mode, delay, nreq, failures, check_count} = {1'b1, 8'h0a, 8'h00, 64'h0};
        cmds = '{16'h0280, 16'h82c0, 16'h8380, 16'h0384, 16'h83b4, 16'h03b4, 16'h0010};
        bits = '{5, 6, 4, 3, 2, 1, 0};
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        rd(2'h3, r);
        check32(r, 32'h0001_007f);
        rd(2'h2, r);
        check32(r, 32'h0000_0000);
        wr(2'h3, 32'h0000_0000);
        rd(2'h3, r);
        check32(r, 32'h0001_007f);
        rd_local(HABS_AC_IRQ_STATUS, r);
        check32(r, 32'h0000_0000);
        wr(2'h2, {22'h000000, HABS_AC_IRQ_ENABLE});
        rd(2'h3, r);
        check32(r, 32'h0001_007f);
        rd(2'h1, r);
        check32(r, 32'h0000_0000);
        wr_local(HABS_AC_IRQ_ENABLE, 32'hffff_ffff);
        rd_local(HABS_AC_IRQ_ENABLE, r);
        check32(r, 32'h0000_007f);
        wr_local(HABS_AC_MGMT_WDATA, 32'hffff_1234);
        rd_local(HABS_AC_MGMT_WDATA, r);
        check32(r, 32'h0000_1234);
        exp_st = 32'h0000_0000;
        for (i = 0; i < 7; i++) begin
            // Management accesses run long, the rest short
            delay = (bits[i] == 2 || bits[i] == 1) ? 8'h28 : 8'h0a;
            mac_access(cmds[i], bits[i], 32'h5a00_0000 | 32'(i));
            exp_st = exp_st | (32'h0000_0001 << bits[i]);
            rd_local(HABS_AC_IRQ_STATUS, r);
            check32(r, exp_st);
            check1(irq, 1'b1);
        end
        repeat (20) @(negedge mclk);
        check1(irq, 1'b1);
        wr_local(HABS_AC_IRQ_STATUS, 32'h0000_0000);
        rd_local(HABS_AC_IRQ_STATUS, r);
        check32(r, 32'h0000_0000);
        check1(irq, 1'b0);
        delay = 8'h0a;
        wr_local(HABS_AC_IRQ_ENABLE, 32'h0000_003f);
        mac_access(16'h82c0, 6, 32'h0000_00c3);
        rd_local(HABS_AC_IRQ_STATUS, r);
        check32(r, 32'h0000_0000);
        check1(irq, 1'b0);
        mac_access(16'h0280, 5, 32'h0000_0000);
        bus_access_mode = 1'b0;
        rd_local(HABS_AC_IRQ_STATUS, r);
        check32(r, 32'h0000_0020);
        check1(irq, 1'b0);
        bus_access_mode = 1'b1;
        repeat (4) @(negedge mclk);
        check1(irq, 1'b1);
        print_verdict();
    end
endmodule
